// ===== sahc_defines.svh
`ifndef SAHC_DEFINES_SVH
`define SAHC_DEFINES_SVH

// Register byte offsets (AHB-Lite, one word each)
`define SAHC_OFF_CMD 12'h100
`define SAHC_OFF_ADDR 12'h108
`define SAHC_OFF_WDATA 12'h104
`define SAHC_OFF_REPLY 12'h10c
`define SAHC_OFF_RDATA 12'h110
`define SAHC_OFF_MISC 12'h180
`define SAHC_OFF_MVAL 12'h184
`define SAHC_OFF_NVAL 12'h188
`define SAHC_OFF_TSTAMP 12'h18c
`define SAHC_OFF_LINK 12'h190
`define SAHC_OFF_ISTAT 12'h140
`define SAHC_OFF_IEN 12'h144
`define SAHC_OFF_ICLR 12'h148

// Command register fields
`define SAHC_CMD_LEN_LSB 0
`define SAHC_CMD_TYPE_LSB 8
`define SAHC_CMD_GO_BIT 12
`define SAHC_CMD_CONT_BIT 13
`define SAHC_CMD_AONLY_BIT 14

// Interrupt status bits
`define SAHC_IRQ_HPIRQ 0
`define SAHC_IRQ_CONN 1
`define SAHC_IRQ_DISC 2
`define SAHC_IRQ_REPLY 3

// Fixed N value in asynchronous stream clock mode
`define SAHC_FIXED_N 24'h008000

// Hot-plug timing at 10 MHz (100 ns)
`define SAHC_CLK_NS 100
`define SAHC_SAMPLE_US 260
`define SAHC_IRQ_MIN_US 500
`define SAHC_IRQ_MAX_US 1000
`define SAHC_DISC_US 2000
`define SAHC_SAMPLE_CYC ((`SAHC_SAMPLE_US * 1000 + `SAHC_CLK_NS - 1) / `SAHC_CLK_NS)
`define SAHC_IRQ_MIN_TICKS (`SAHC_IRQ_MIN_US / `SAHC_SAMPLE_US)
`define SAHC_IRQ_MAX_TICKS (`SAHC_IRQ_MAX_US / `SAHC_SAMPLE_US)
`define SAHC_DISC_TICKS (`SAHC_DISC_US / `SAHC_SAMPLE_US + 1)

`endif

// ===== sahc_pkg.sv
package sahc_pkg;
  typedef enum logic [1:0] {
    SAHC_CMD_WRITE = 2'h0,
    SAHC_CMD_READ = 2'h1,
    SAHC_CMD_WSTAT = 2'h2
  } sahc_cmd_t;

  typedef enum logic [1:0] {
    SAHC_REP_ACK = 2'h0,
    SAHC_REP_DEFER = 2'h1,
    SAHC_REP_PARTIAL = 2'h2
  } sahc_reply_t;
endpackage : sahc_pkg

// ===== sahc_link_if.sv
`timescale 1ns/1ns
interface sahc_link_if;
  logic req;
  logic [1:0] cmd;
  logic cont;
  logic addr_only;
  logic [6:0] dev_addr;
  logic [3:0] len;
  logic [31:0] wdata;
  logic rsp;
  logic [1:0] reply;
  logic [31:0] rdata;
  logic hot_plug_line;

  modport source (
    output req, cmd, cont, addr_only, dev_addr, len, wdata,
    input rsp, reply, rdata, hot_plug_line
  );
  modport sink (
    input req, cmd, cont, addr_only, dev_addr, len, wdata,
    output rsp, reply, rdata, hot_plug_line
  );
endinterface : sahc_link_if

// ===== sahc_source.sv
`timescale 1ns/1ns
`include "sahc_defines.svh"
// Operation
// - host loads address, then command bit 12
// - status with continue cleared idles bus
// - reissue identical read after defer
// - sink answers repeated read with data
// - abandon read: other target, write, address-only
// - poll write status after partial ack
// - repeat identical write until full ack
// - abandon write: other target, read, address-only
// - write defer handled by poll, repeat, abort
// - misc bit 0 selects synchronous clock mode
// - synchronous mode sends programmed M and N
// - asynchronous mode sends fixed N, interface M
// - debounce hot-plug every 250 us or more
// - 500 us to 1 ms pulse is IRQ
// - low over 2 ms: disconnect, link down
// - host reads sink config space on interrupt
// - plug change high connects, low disconnects
// - IRQ event in status bit 0
module sahc_source #(
  parameter int SAMPLE_CYC = `SAHC_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Stream clocking, link state and interrupt
  input wire logic [23:0] stream_m_i,
  output logic [23:0] video_stamp_m_o,
  output logic [23:0] video_stamp_n_o,
  output logic link_up_o,
  output logic irq_o,
  // Link
  sahc_link_if.source link
);
  typedef struct packed {
    logic aph;
    logic [11:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic [6:0] dev;
    logic [31:0] wdat;
    logic [3:0] len;
    logic [1:0] cmd;
    logic cont;
    logic aonly;
    logic req;
    logic busy;
    logic [1:0] reply;
    logic [31:0] rxdata;
    logic [2:0] misc;
    logic [23:0] mval;
    logic [23:0] nval;
    logic [23:0] m_out;
    logic [23:0] n_out;
    logic link_up;
    logic [3:0] stat;
    logic [3:0] en;
    logic irq;
    logic [2:0] hp_sync;
    logic hp_db;
    logic [15:0] tick_cnt;
    logic [7:0] low_ticks;
    logic plugged;
  } sahc_src_state_t;

  sahc_src_state_t s;
  sahc_src_state_t next_s;
  logic [3:0] ev;
  logic [15:0] sample_last;

  assign sample_last = 16'(SAMPLE_CYC - 1);

  always_comb begin
    next_s = s;
    ev = 4'h0;
    next_s.hp_sync = {s.hp_sync[1:0], link.hot_plug_line};
    next_s.req = 1'b0;
    // AHB data phase: writes take effect here, reads answer here
    if (s.aph && s.wr) begin
      case (s.addr)
        `SAHC_OFF_ADDR: next_s.dev = hwdata_i[6:0];
        `SAHC_OFF_WDATA: next_s.wdat = hwdata_i;
        `SAHC_OFF_CMD: begin
          if (hwdata_i[`SAHC_CMD_GO_BIT] && !s.busy) begin
            // Registered address and data are reused as is; length comes from the command word
            next_s.cmd = hwdata_i[`SAHC_CMD_TYPE_LSB +: 2];
            next_s.len = hwdata_i[`SAHC_CMD_LEN_LSB +: 4];
            next_s.cont = hwdata_i[`SAHC_CMD_CONT_BIT];
            // Any differing command other than a write status poll abandons the pending one
            next_s.aonly = hwdata_i[`SAHC_CMD_AONLY_BIT];
            next_s.req = 1'b1;
            next_s.busy = 1'b1;
          end
        end
        `SAHC_OFF_MISC: next_s.misc = hwdata_i[2:0];
        `SAHC_OFF_MVAL: next_s.mval = hwdata_i[23:0];
        `SAHC_OFF_NVAL: next_s.nval = hwdata_i[23:0];
        `SAHC_OFF_IEN: next_s.en = hwdata_i[3:0];
        `SAHC_OFF_ICLR: next_s.stat = s.stat & ~hwdata_i[3:0];
        `SAHC_OFF_LINK: next_s.link_up = hwdata_i[0];
        default: ;
      endcase
    end
    next_s.rdata = 32'h0;
    next_s.aph = hsel_i && hready_i && htrans_i[1];
    if (next_s.aph) begin
      next_s.addr = haddr_i;
      next_s.wr = hwrite_i;
      if (!hwrite_i) begin
        case (haddr_i)
          `SAHC_OFF_CMD: next_s.rdata = {17'h0, s.aonly, s.cont, 1'b0,
            2'h0, s.cmd, 4'h0, s.len} | {31'h0, s.busy};
          `SAHC_OFF_ADDR: next_s.rdata = {25'h0, s.dev};
          `SAHC_OFF_WDATA: next_s.rdata = s.wdat;
          `SAHC_OFF_REPLY: next_s.rdata = {29'h0, s.busy, s.reply};
          `SAHC_OFF_RDATA: next_s.rdata = s.rxdata;
          `SAHC_OFF_MISC: next_s.rdata = {29'h0, s.misc};
          `SAHC_OFF_MVAL: next_s.rdata = {8'h0, s.mval};
          `SAHC_OFF_NVAL: next_s.rdata = {8'h0, s.nval};
          `SAHC_OFF_TSTAMP: next_s.rdata = {8'h0, s.m_out};
          `SAHC_OFF_LINK: next_s.rdata = {30'h0, s.plugged, s.link_up};
          `SAHC_OFF_ISTAT: next_s.rdata = {28'h0, s.stat};
          `SAHC_OFF_IEN: next_s.rdata = {28'h0, s.en};
          default: next_s.rdata = 32'h0;
        endcase
      end
    end
    if (s.busy && link.rsp) begin
      next_s.busy = 1'b0;
      next_s.reply = link.reply;
      next_s.rxdata = link.rdata;
      ev[`SAHC_IRQ_REPLY] = 1'b1;
    end
    if (s.misc[0]) begin
      next_s.m_out = s.mval;
      next_s.n_out = s.nval;
    end else begin
      next_s.m_out = stream_m_i;
      next_s.n_out = `SAHC_FIXED_N;
    end
    // Debounced sampling at a fixed tick
    next_s.tick_cnt = (s.tick_cnt == sample_last) ? 16'h0
      : s.tick_cnt + 16'h1;
    if (s.tick_cnt == sample_last) begin
      if (s.hp_sync[2] == s.hp_sync[1]) begin
        next_s.hp_db = s.hp_sync[2];
      end
      if (!s.hp_db) begin
        if (s.low_ticks != 8'hff) begin
          next_s.low_ticks = s.low_ticks + 8'h1;
        end
        if (s.plugged && s.low_ticks + 8'h1 ==
            8'(`SAHC_DISC_TICKS)) begin
          next_s.plugged = 1'b0;
          next_s.link_up = 1'b0;
          ev[`SAHC_IRQ_DISC] = 1'b1;
        end
      end else begin
        next_s.low_ticks = 8'h0;
        if (!s.plugged) begin
          next_s.plugged = 1'b1;
          ev[`SAHC_IRQ_CONN] = 1'b1;
        end else if (s.low_ticks >= 8'(`SAHC_IRQ_MIN_TICKS) &&
                     s.low_ticks <= 8'(`SAHC_IRQ_MAX_TICKS)) begin
          ev[`SAHC_IRQ_HPIRQ] = 1'b1;
        end
      end
    end
    // Set wins over clear; host then inspects sink config space
    next_s.stat = next_s.stat | ev;
    next_s.irq = |(next_s.stat & next_s.en);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata_o = s.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign video_stamp_m_o = s.m_out;
  assign video_stamp_n_o = s.n_out;
  assign link_up_o = s.link_up;
  assign irq_o = s.irq;
  assign link.req = s.req;
  assign link.cmd = s.cmd;
  assign link.cont = s.cont;
  assign link.addr_only = s.aonly;
  assign link.dev_addr = s.dev;
  assign link.len = s.len;
  assign link.wdata = s.wdat;
endmodule : sahc_source

// ===== sahc_sink.sv
`timescale 1ns/1ns
`include "sahc_defines.svh"
module sahc_sink #(
  parameter int DEFERS = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sink side controls
  input wire logic hot_plug_i,
  input wire logic [31:0] i2c_rdata_i,
  output logic pending_o,
  // Link
  sahc_link_if.sink link
);
  typedef struct packed {
    logic rsp;
    logic [1:0] reply;
    logic [31:0] rdata;
    logic pend;
    logic [1:0] pcmd;
    logic [6:0] pdev;
    logic [3:0] plen;
    logic [7:0] left;
    logic hp;
  } sahc_snk_state_t;

  sahc_snk_state_t s;
  sahc_snk_state_t next_s;
  logic same;

  always_comb begin
    next_s = s;
    next_s.rsp = 1'b0;
    next_s.hp = hot_plug_i;
    same = s.pend && link.dev_addr == s.pdev && link.len == s.plen;
    if (s.pend && s.left != 8'h0) begin
      next_s.left = s.left - 8'h1;
    end
    if (link.req) begin
      next_s.rsp = 1'b1;
      next_s.reply = sahc_pkg::SAHC_REP_ACK;
      next_s.rdata = i2c_rdata_i;
      if (link.addr_only && !link.cont) begin
        next_s.pend = 1'b0;
      end else if (link.cmd == sahc_pkg::SAHC_CMD_WSTAT) begin
        next_s.reply = (s.pend && s.left != 8'h0)
          ? sahc_pkg::SAHC_REP_PARTIAL : sahc_pkg::SAHC_REP_ACK;
        if (s.left == 8'h0 && !link.cont) begin
          next_s.pend = 1'b0;
        end
      end else if (same && link.cmd == s.pcmd) begin
        next_s.reply = (s.left != 8'h0) ? ((s.pcmd ==
          sahc_pkg::SAHC_CMD_READ) ? sahc_pkg::SAHC_REP_DEFER
          : sahc_pkg::SAHC_REP_PARTIAL) : sahc_pkg::SAHC_REP_ACK;
        if (s.left == 8'h0) begin
          next_s.pend = 1'b0;
        end
      end else begin
        // New transfer starts; deferred first
        next_s.pend = 1'b1;
        next_s.pcmd = link.cmd;
        next_s.pdev = link.dev_addr;
        next_s.plen = link.len;
        next_s.left = 8'(DEFERS);
        next_s.reply = sahc_pkg::SAHC_REP_DEFER;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.rsp = s.rsp;
  assign link.reply = s.reply;
  assign link.rdata = s.rdata;
  assign link.hot_plug_line = s.hp;
  assign pending_o = s.pend;
endmodule : sahc_sink

// ===== sahc_link_asserts.sv
`timescale 1ns/1ns
module sahc_link_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic req,
  input wire logic [1:0] cmd,
  input wire logic cont,
  input wire logic addr_only,
  input wire logic [6:0] dev_addr,
  input wire logic [3:0] len,
  input wire logic [31:0] wdata,
  input wire logic rsp,
  input wire logic [1:0] reply,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    req;
  endsequence
  sequence s_ans;
    ##1 rsp;
  endsequence
  property p_answer;
    s_req |-> s_ans;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer one cycle after request");
  property p_cause;
    rsp |-> $past(req);
  endproperty
  a_cause: assert property (p_cause)
    else $error("answer without request");
  property p_pulse;
    s_req |=> !req ##1 !req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request longer than one cycle");
  property p_alone;
    req |-> !rsp;
  endproperty
  a_alone: assert property (p_alone)
    else $error("request while answer pending");
  property p_fields;
    $changed({cmd, cont, addr_only, len}) |-> req;
  endproperty
  a_fields: assert property (p_fields)
    else $error("transfer fields changed without request");
  property p_steady;
    req |-> $stable({dev_addr, wdata});
  endproperty
  a_steady: assert property (p_steady)
    else $error("transfer target changed with request");
  property p_hold;
    $changed({reply, rdata}) |-> rsp;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply changed without answer");
  property p_rdrep;
    rsp && cmd == sahc_pkg::SAHC_CMD_READ |-> reply != 2'h2 && reply != 2'h3;
  endproperty
  a_rdrep: assert property (p_rdrep)
    else $error("read answered with partial");
  property p_wsrep;
    rsp && cmd == sahc_pkg::SAHC_CMD_WSTAT |-> reply != 2'h1 && reply != 2'h3;
  endproperty
  a_wsrep: assert property (p_wsrep)
    else $error("status poll answered with defer");
  property p_wrrep;
    rsp && cmd == sahc_pkg::SAHC_CMD_WRITE |-> reply != 2'h3;
  endproperty
  a_wrrep: assert property (p_wrrep)
    else $error("illegal reply to write");
endmodule : sahc_link_asserts

// ===== tb_top.sv
`timescale 1ns/1ns
`include "sahc_defines.svh"
module tb_top;
  logic clk_i, rst_i, hsel, hwrite, hot_plug, hready, hresp, rdy_q;
  logic irq, link_up, pend;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv, rd_q;
  logic [23:0] m_out, n_out, m_in;
  int bad_count, n_checks;
  localparam logic [23:0] M_IN = 24'h123456;
  localparam logic [31:0] I2C_D = 32'hcafe0123;
  localparam logic [1:0] ACK = sahc_pkg::SAHC_REP_ACK;
  localparam logic [1:0] DEF = sahc_pkg::SAHC_REP_DEFER;
  localparam logic [1:0] PAR = sahc_pkg::SAHC_REP_PARTIAL;
  sahc_link_if link ();
  sahc_source #(.SAMPLE_CYC(4)) sahc_source_inst (.clk_i(clk_i),
    .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .stream_m_i(m_in), .video_stamp_m_o(m_out),
    .video_stamp_n_o(n_out), .link_up_o(link_up), .irq_o(irq),
    .link(link));
  sahc_sink #(.DEFERS(40)) sahc_sink_inst (.clk_i(clk_i), .rst_i(rst_i),
    .hot_plug_i(hot_plug), .i2c_rdata_i(I2C_D), .pending_o(pend),
    .link(link));
  sahc_link_asserts sahc_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
    .req(link.req), .cmd(link.cmd), .cont(link.cont),
    .addr_only(link.addr_only), .dev_addr(link.dev_addr),
    .len(link.len), .wdata(link.wdata), .rsp(link.rsp),
    .reply(link.reply), .rdata(link.rdata));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Edge samples of the slave answer
  always @(posedge clk_i) begin
    rdy_q <= hready;
    rd_q <= hrdata;
  end
  task print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do tick(1); while (rdy_q !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do tick(1); while (rdy_q !== 1'b1);
    rdv = rd_q;
  endtask : bus
  task rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rdc
  // Issue a command, then check busy clear and the reply code
  task go(input logic [31:0] c, input logic [1:0] r);
    bus(1'b1, `SAHC_OFF_CMD, c);
    tick(4);
    rdc(`SAHC_OFF_REPLY, {30'h0, r});
  endtask : go
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hot_plug} = '0;
    hsize = 3'h2;
    m_in = M_IN;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk({8'h0, n_out}, {8'h0, `SAHC_FIXED_N});
    chk({8'h0, m_out}, {8'h0, M_IN});
    bus(1'b1, `SAHC_OFF_MISC, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b1, `SAHC_OFF_MVAL, 32'h0abcde);
    bus(1'b1, `SAHC_OFF_NVAL, 32'h054321);
    tick(2);
    chk({8'h0, m_out}, 32'h0abcde);
    chk({8'h0, n_out}, 32'h054321);
    bus(1'b1, `SAHC_OFF_MISC, 32'h0);
    tick(2);
    chk({8'h0, n_out}, {8'h0, `SAHC_FIXED_N});
    m_in <= 24'h654321;
    tick(2);
    chk({8'h0, m_out}, 32'h654321);
    rdc(`SAHC_OFF_TSTAMP, 32'h654321);
    rdc(12'h0f0, 32'h0);
    bus(1'b1, `SAHC_OFF_ADDR, 32'h50);
    go(32'h1104, DEF);
    chk({31'h0, pend}, 32'h1);
    go(32'h1104, DEF);
    tick(50);
    go(32'h1104, ACK);
    rdc(`SAHC_OFF_RDATA, I2C_D);
    bus(1'b1, `SAHC_OFF_WDATA, 32'h5a5a1234);
    go(32'h1004, DEF);
    go(32'h1004, PAR);
    go(32'h1204, PAR);
    tick(50);
    go(32'h1204, ACK);
    chk({31'h0, pend}, 32'h0);
    go(32'h1004, DEF);
    bus(1'b1, `SAHC_OFF_ADDR, 32'h51);
    go(32'h1104, DEF);
    go(32'h1004, DEF);
    go(32'h5004, ACK);
    go(32'h1004, DEF);
    go(32'h1104, DEF);
    go(32'h5104, ACK);
    chk({31'h0, pend}, 32'h0);
    bus(1'b1, `SAHC_OFF_IEN, 32'h1);
    bus(1'b1, `SAHC_OFF_ICLR, 32'hf);
    hot_plug <= 1'b1;
    tick(40);
    bus(1'b0, `SAHC_OFF_ISTAT, 32'h0);
    chk(rdv & 32'h2, 32'h2);
    bus(1'b1, `SAHC_OFF_ICLR, 32'hf);
    hot_plug <= 1'b0;
    tick(9);
    hot_plug <= 1'b1;
    tick(40);
    bus(1'b0, `SAHC_OFF_ISTAT, 32'h0);
    chk(rdv & 32'h7, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `SAHC_OFF_ICLR, 32'hf);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `SAHC_OFF_LINK, 32'h1);
    rdc(`SAHC_OFF_LINK, 32'h3);
    hot_plug <= 1'b0;
    tick(60);
    bus(1'b0, `SAHC_OFF_ISTAT, 32'h0);
    chk(rdv & 32'h4, 32'h4);
    chk({31'h0, link_up}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule : tb_top
